// [power_on_config_regs.svh]
// power-on configuration register layout, reset values and timing counts
// assumes: included by name from every module that reads these constants
//
// Behaviour
// - data error checking enable, read/write bit 1, cleared after reset
// - response error and checker-pair observation enable, bit 2, off
// - driver enables at bits 3, 4, 6, 7 off at reset; bit 5 reserved
// - bits 13, 10, 12 latched from address pins 7, 8, 10 at reset
// - bits 14, 15, 8, 9 latched from pins 6, 5, flush, init at reset
// - interrupt cluster ID from address pins 12 and 11 at bits 17:16
// - arbitration ID from four bus request pins at bits 21:20
// - core-to-bus ratio code read-only at bits 25:22 per code table
// - standby enable bit 26 read/write, set after reset; 19:18 reserved
// - whole configuration readable as one 32-bit register
// - init order: clock loop sync, arbitration, self-test, code fetch
// - bus arbiter from agent ID and pair mode; interrupt ID adds cluster
// - self-test runs only when the latched option asks for it
// - drive block-next-request stall from reset release until accepting
// - multiplexed pins keep configuration meaning until first strobe
// - no new request until priority and block-next both inactive at sample
// - ratio pins sampled during reset, latched at release, then normal
`ifndef POWER_ON_CONFIG_REGS_SVH
`define POWER_ON_CONFIG_REGS_SVH

// ====================================================================
// bit positions
`define POC_DATA_CHK      1
`define POC_RESP_CHK      2
`define POC_ADDRESS_ERROR_N_DRV      3
`define POC_BUS_ERROR_N_BUS_DRV  4
`define POC_BUS_ERROR_N_INT_DRV  6
`define POC_BUS_INITIALIZE_N_DRV     7
`define POC_TRISTATE      8
`define POC_BIST          9
`define POC_ADDRESS_ERROR_N_OBS      10
`define POC_BUS_INITIALIZE_N_OBS     12
`define POC_IOQ1          13
`define POC_VEC1M         14
`define POC_FRC           15
`define POC_CLUSTER_LSB   16
`define POC_ARB_LSB       20
`define POC_RATIO_LSB     22
`define POC_STANDBY       26

// ====================================================================
// masks and reset values
`define POC_RW_MASK       32'h0400_00DE
`define POC_RW_RESET      32'h0400_0000
`define POC_RO_MASK       32'h03F3_F700
`define POC_RATIO_RSVD    4'h8

// ====================================================================
// reset vectors
`define POC_VEC_HIGH      40'h00_FFFF_FFF0
`define POC_VEC_1MB       40'h00_000F_FFF0

// ====================================================================
// timing
`define POC_CLK_PERIOD_NS 100
`define POC_PLL_LOCK_NS   1600

`endif

// [power_on_config_pkg.sv]
// types shared by the power-on configuration modules
// assumes: nothing beyond the language
`default_nettype none

package power_on_config_pkg;

  // ====================================================================
  // initialization sequence, gray along the usual path
  typedef enum logic [2:0] {
    st_pll   = 3'b000,
    st_arb   = 3'b001,
    st_bist  = 3'b011,
    st_fetch = 3'b010,
    st_run   = 3'b110
  } init_state_type;

  typedef logic [3:0] ratio_code_type;

endpackage

`default_nettype wire

// [cfg_if.sv]
// latched configuration out to the sequencer, sequence status back
// assumes: one producer of each group, same clock on both sides
`default_nettype none

interface cfg_if;
  logic       bist_req;
  logic       frc_en;
  logic [1:0] agent_id;
  logic [1:0] cluster_id;
  logic       stall;
  logic       in_bist;
  logic       fetch_pulse;
  logic [1:0] bus_arb_id;
  logic [3:0] intc_arb_id;

  modport cfg (output bist_req, frc_en, agent_id, cluster_id,
               input  stall, in_bist, fetch_pulse, bus_arb_id, intc_arb_id);
  modport seq (input  bist_req, frc_en, agent_id, cluster_id,
               output stall, in_bist, fetch_pulse, bus_arb_id, intc_arb_id);
endinterface

`default_nettype wire

// [ratio_decode.sv]
// ratio strap levels to register code
// assumes: pins given as electrical levels, 1 = high
`default_nettype none
`include "power_on_config_regs.svh"

module ratio_decode (
  input  wire logic [3:0]                      pins,
  output var        power_on_config_pkg::ratio_code_type code
);
  // ====================================================================
  // pins = {lint1, lint0, ignore_numeric_error_n, address_bit20_mask_n}
  always_comb begin
    case (pins)
      4'h0: code = 4'hC;
      4'h1: code = 4'h2;
      4'h2: code = 4'h1;
      4'h3: code = 4'h0;
      4'h4: code = 4'h7;
      4'h5: code = 4'h6;
      4'h6: code = 4'h5;
      4'h7: code = 4'h4;
      4'h8: code = 4'hB;
      4'h9: code = 4'hA;
      4'hA: code = 4'h9;
      4'hB: code = `POC_RATIO_RSVD;
      4'hC: code = 4'hF;
      4'hD: code = 4'hE;
      4'hE: code = 4'hD;
      default: code = 4'h3;
    endcase
  end
endmodule // ratio_decode

`default_nettype wire

// [init_sequencer.sv]
// initialization sequence after reset release
// assumes: configuration in cfg is stable once reset is released
`default_nettype none

module init_sequencer #(
  parameter int unsigned PLL_LOCK_CYCLES = 16
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic bist_done,
  cfg_if.seq        cfg
);
  power_on_config_pkg::init_state_type state_r, state_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [1:0]  bus_arb_r, bus_arb_nxt;
  logic [3:0]  intc_arb_r, intc_arb_nxt;

  // ====================================================================
  // sequence
  always_comb begin
    state_nxt    = state_r;
    cnt_nxt      = cnt_r;
    bus_arb_nxt  = bus_arb_r;
    intc_arb_nxt = intc_arb_r;
    if (!nrst) begin
      state_nxt    = power_on_config_pkg::st_pll;
      cnt_nxt      = 16'h0000;
      bus_arb_nxt  = 2'h0;
      intc_arb_nxt = 4'h0;
    end else begin
      case (state_r)
        power_on_config_pkg::st_pll: begin
          if (cnt_r == 16'(PLL_LOCK_CYCLES - 1)) begin
            state_nxt = power_on_config_pkg::st_arb;
            cnt_nxt   = 16'h0000;
          end else begin
            cnt_nxt = cnt_r + 16'h0001;
          end
        end
        power_on_config_pkg::st_arb: begin
          bus_arb_nxt  = {cfg.agent_id[1], cfg.agent_id[0] & ~cfg.frc_en};
          intc_arb_nxt = {cfg.cluster_id, cfg.agent_id};
          state_nxt = cfg.bist_req ? power_on_config_pkg::st_bist
                                   : power_on_config_pkg::st_fetch;
        end
        power_on_config_pkg::st_bist: begin
          if (bist_done) begin
            state_nxt = power_on_config_pkg::st_fetch;
          end
        end
        power_on_config_pkg::st_fetch: begin
          state_nxt = power_on_config_pkg::st_run;
        end
        power_on_config_pkg::st_run: begin
          state_nxt = state_r;
        end
        default: begin
          state_nxt = power_on_config_pkg::st_pll;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    state_r    <= state_nxt;
    cnt_r      <= cnt_nxt;
    bus_arb_r  <= bus_arb_nxt;
    intc_arb_r <= intc_arb_nxt;
  end

  // stall until the arbiter is set up
  assign cfg.stall       = (state_r == power_on_config_pkg::st_pll) ||
                           (state_r == power_on_config_pkg::st_arb);
  assign cfg.in_bist     = (state_r == power_on_config_pkg::st_bist);
  assign cfg.fetch_pulse = (state_r == power_on_config_pkg::st_fetch);
  assign cfg.bus_arb_id  = bus_arb_r;
  assign cfg.intc_arb_id = intc_arb_r;

  // ====================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  bist_skip_a : assert property (
    (state_r == power_on_config_pkg::st_arb) && !cfg.bist_req |=>
      state_r == power_on_config_pkg::st_fetch)
    else $error("self-test not skipped");
  bist_run_a : assert property (
    (state_r == power_on_config_pkg::st_arb) && cfg.bist_req |=>
      cfg.in_bist && !cfg.fetch_pulse)
    else $error("self-test not entered");
  pll_order_a : assert property (
    (state_r == power_on_config_pkg::st_arb) |->
      $past(state_r) == power_on_config_pkg::st_pll)
    else $error("arbitration before clock sync");
endmodule // init_sequencer

`default_nettype wire

// [power_on_config_and_init.sv]
// power-on configuration register with strap capture and init control
// assumes: pins synchronous to clk; software access over the msr port
`default_nettype none
`include "power_on_config_regs.svh"

module power_on_config_and_init #(
  parameter int unsigned PLL_LOCK_CYCLES =
    (`POC_PLL_LOCK_NS + `POC_CLK_PERIOD_NS - 1) / `POC_CLK_PERIOD_NS
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        flush_n,
  input  wire logic        init_n,
  input  wire logic        addr_pin_5_n,
  input  wire logic        addr_pin_6_n,
  input  wire logic        addr_pin_7_n,
  input  wire logic        addr_pin_8_n,
  input  wire logic        addr_pin_10_n,
  input  wire logic        addr_pin_11_n,
  input  wire logic        addr_pin_12_n,
  input  wire logic [3:0]  bus_request_line_n,
  input  wire logic [1:0]  local_interrupt_pins,
  input  wire logic        address_bit20_mask_n,
  input  wire logic        ignore_numeric_error_n,
  input  wire logic        address_strobe_n,
  input  wire logic        block_next_request_in_n,
  input  wire logic        priority_agent_request_n,
  input  wire logic        bist_done,
  input  wire logic        msr_wr,
  input  wire logic        msr_rd,
  input  wire logic [31:0] msr_wdata,
  output logic      [31:0] msr_rdata,
  output logic             msr_rvalid,
  output logic             data_check_en,
  output logic             resp_check_en,
  output logic             address_error_drv_en,
  output logic             bus_error_bus_drv_en,
  output logic             bus_error_int_drv_en,
  output logic             bus_initialize_drv_en,
  output logic             standby_en,
  output logic             block_next_request_out_n,
  output logic             block_next_request_oe_n,
  output logic             bist_start,
  output logic             fetch_req,
  output logic      [39:0] fetch_addr,
  output logic      [1:0]  bus_arb_id,
  output logic      [3:0]  intc_arb_id,
  output logic             may_request,
  output logic             pins_normal,
  output logic             straps_latched
);
  cfg_if cfg ();

  power_on_config_pkg::ratio_code_type ratio_code;
  logic [31:0] ro_r, ro_nxt, ro_smp;
  logic [31:0] rw_r, rw_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [1:0]  agent_r, agent_nxt, agent_smp;
  logic [39:0] fetch_addr_r, fetch_addr_nxt;
  logic        smp_tgl_r, smp_tgl_nxt;
  logic        quiet_r, quiet_nxt;
  logic        normal_r, normal_nxt;
  logic        latched_r, latched_nxt;
  logic        first_r, first_nxt;

  // ====================================================================
  // strap capture
  ratio_decode u_ratio (
    .pins ({local_interrupt_pins, ignore_numeric_error_n,
            address_bit20_mask_n}),
    .code (ratio_code)
  );

  always_comb begin
    // only one request line low at release
    case (bus_request_line_n)
      4'b0111: agent_smp = 2'h1;
      4'b1011: agent_smp = 2'h2;
      4'b1101: agent_smp = 2'h3;
      default: agent_smp = 2'h0;
    endcase
  end

  always_comb begin
    ro_smp = 32'h0000_0000;
    ro_smp[`POC_TRISTATE] = ~flush_n;
    ro_smp[`POC_BIST]     = ~init_n;
    ro_smp[`POC_VEC1M]    = ~addr_pin_6_n;
    ro_smp[`POC_FRC]      = ~addr_pin_5_n;
    ro_smp[`POC_ADDRESS_ERROR_N_OBS]  = ~addr_pin_8_n;
    ro_smp[`POC_BUS_INITIALIZE_N_OBS] = ~addr_pin_10_n;
    ro_smp[`POC_IOQ1]      = ~addr_pin_7_n;
    // cluster id, asserted pin reads one
    ro_smp[`POC_CLUSTER_LSB +: 2] = {~addr_pin_12_n, ~addr_pin_11_n};
    // arbitration id, checker shares its master's
    ro_smp[`POC_ARB_LSB +: 2] = {agent_smp[1],
                                 agent_smp[0] & addr_pin_5_n};
    ro_smp[`POC_RATIO_LSB +: 4] = ratio_code;
  end

  // sync reset lets straps follow the pins until the release edge
  always_comb begin
    ro_nxt    = ro_r;
    agent_nxt = agent_r;
    if (!nrst) begin
      ro_nxt    = ro_smp;
      agent_nxt = agent_smp;
    end
  end

  always_ff @(posedge clk) begin
    ro_r    <= ro_nxt;
    agent_r <= agent_nxt;
  end

  assign cfg.bist_req   = ro_r[`POC_BIST];
  assign cfg.frc_en     = ro_r[`POC_FRC];
  assign cfg.agent_id   = agent_r;
  assign cfg.cluster_id = ro_r[`POC_CLUSTER_LSB +: 2];

  // ====================================================================
  // software port
  always_comb begin
    rw_nxt     = rw_r;
    rdata_nxt  = rdata_r;
    rvalid_nxt = 1'b0;
    if (!nrst) begin
      rw_nxt    = `POC_RW_RESET;
      rdata_nxt = 32'h0000_0000;
    end else begin
      if (msr_wr) begin
        rw_nxt = msr_wdata & `POC_RW_MASK;
      end
      if (msr_rd) begin
        rdata_nxt  = ro_r | rw_r;
        rvalid_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    rw_r     <= rw_nxt;
    rdata_r  <= rdata_nxt;
    rvalid_r <= rvalid_nxt;
  end

  assign msr_rdata             = rdata_r;
  assign msr_rvalid            = rvalid_r;
  assign data_check_en         = rw_r[`POC_DATA_CHK];
  assign resp_check_en         = rw_r[`POC_RESP_CHK];
  assign address_error_drv_en  = rw_r[`POC_ADDRESS_ERROR_N_DRV];
  assign bus_error_bus_drv_en  = rw_r[`POC_BUS_ERROR_N_BUS_DRV];
  assign bus_error_int_drv_en  = rw_r[`POC_BUS_ERROR_N_INT_DRV];
  assign bus_initialize_drv_en = rw_r[`POC_BUS_INITIALIZE_N_DRV];
  assign standby_en            = rw_r[`POC_STANDBY];

  // ====================================================================
  // init sequence and bus hand-over
  init_sequencer #(
    .PLL_LOCK_CYCLES (PLL_LOCK_CYCLES)
  ) u_seq (
    .clk       (clk),
    .nrst      (nrst),
    .bist_done (bist_done),
    .cfg       (cfg.seq)
  );

  always_comb begin
    fetch_addr_nxt = fetch_addr_r;
    smp_tgl_nxt    = ~smp_tgl_r;
    quiet_nxt      = quiet_r;
    normal_nxt     = normal_r;
    latched_nxt    = 1'b1;
    first_nxt      = 1'b0;
    if (!nrst) begin
      fetch_addr_nxt = 40'h00_0000_0000;
      smp_tgl_nxt    = 1'b0;
      quiet_nxt      = 1'b0;
      normal_nxt     = 1'b0;
      latched_nxt    = 1'b0;
      first_nxt      = 1'b1;
    end else begin
      if (cfg.fetch_pulse) begin
        fetch_addr_nxt = ro_r[`POC_VEC1M] ? `POC_VEC_1MB : `POC_VEC_HIGH;
      end
      // both released at one sample point
      if (smp_tgl_r && !cfg.stall && block_next_request_in_n &&
          priority_agent_request_n) begin
        quiet_nxt = 1'b1;
      end
      if (!address_strobe_n) begin
        normal_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    fetch_addr_r <= fetch_addr_nxt;
    smp_tgl_r    <= smp_tgl_nxt;
    quiet_r      <= quiet_nxt;
    normal_r     <= normal_nxt;
    latched_r    <= latched_nxt;
    first_r      <= first_nxt;
  end

  // drive low while stalling; during reset the pin is left free
  assign block_next_request_out_n = ~(cfg.stall & nrst);
  assign block_next_request_oe_n  = ~(cfg.stall & nrst);
  assign bist_start     = cfg.in_bist;
  assign fetch_req      = cfg.fetch_pulse;
  assign fetch_addr     = fetch_addr_r;
  assign bus_arb_id     = cfg.bus_arb_id;
  assign intc_arb_id    = cfg.intc_arb_id;
  assign may_request    = quiet_r;
  assign pins_normal    = normal_r;
  assign straps_latched = latched_r;

  // ====================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  rw_defaults_a : assert property (
    first_r |-> (rw_r == `POC_RW_RESET) && standby_en && !data_check_en)
    else $error("enables wrong after reset");
  wr_mask_a : assert property (
    msr_wr |=> rw_r == ($past(msr_wdata) & `POC_RW_MASK))
    else $error("write reached a protected bit");
  straps_hold_a : assert property (
    !first_r |-> $stable(ro_r) && $stable(agent_r))
    else $error("strap value moved after reset");
  rd_word_a : assert property (
    msr_rd |=> msr_rvalid && msr_rdata == ($past(ro_r) | $past(rw_r)))
    else $error("read data wrong");
  rd_rsvd_a : assert property (
    msr_rvalid |-> (msr_rdata & ~(`POC_RW_MASK | `POC_RO_MASK)) == 32'h0)
    else $error("reserved bit reads one");
  bnr_stall_a : assert property (
    cfg.stall |-> !block_next_request_out_n && !block_next_request_oe_n)
    else $error("stall not driven");
  req_gate_a : assert property (
    $rose(may_request) |-> $past(smp_tgl_r) && $past(priority_agent_request_n)
      && $past(block_next_request_in_n) && !cfg.stall)
    else $error("request allowed too early");
  pins_free_a : assert property (
    !address_strobe_n |=> pins_normal)
    else $error("pins not handed back");
  arb_id_a : assert property (
    fetch_req |-> bus_arb_id == {agent_r[1], agent_r[0] & ~ro_r[`POC_FRC]}
      && intc_arb_id == {ro_r[`POC_CLUSTER_LSB +: 2], agent_r})
    else $error("arbiter id wrong");
  vec_a : assert property (
    fetch_req |=> fetch_addr == (ro_r[`POC_VEC1M] ? `POC_VEC_1MB
                                                  : `POC_VEC_HIGH))
    else $error("reset vector wrong");

  bist_path_c  : cover property (bist_start ##[1:50] fetch_req);
  skip_path_c  : cover property (!ro_r[`POC_BIST] && fetch_req);
  request_ok_c : cover property ($rose(may_request));
  pins_free_c  : cover property ($rose(pins_normal));
endmodule // power_on_config_and_init

`default_nettype wire

// [sys_agent_model.sv]
// system interface logic and other bus agents seen from the block
// assumes: levels only, open-drain wires pulled up when released
`default_nettype none

module sys_agent_model (
  input  wire logic       nrst,
  input  wire logic [1:0] agent_sel,
  input  wire logic       hold_pri,
  input  wire logic       hold_bnr,
  input  wire logic       bnr_out_n,
  input  wire logic       bnr_oe_n,
  output logic      [3:0] bus_request_line_n,
  output logic            bnr_wire_n,
  output logic            pri_wire_n
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==================================================================
  // request lines
  // line 0 asserted in reset
  // each agent sees line 0 on its own pin, so the pattern names the id
  always_comb begin
    case (agent_sel)
      2'h0: bus_request_line_n = nrst ? 4'hF : 4'hE;
      2'h1: bus_request_line_n = nrst ? 4'hF : 4'h7;
      2'h2: bus_request_line_n = nrst ? 4'hF : 4'hB;
      default: bus_request_line_n = nrst ? 4'hF : 4'hD;
    endcase
  end

  // ==================================================================
  // shared wires
  // others release unless told
  assign bnr_wire_n = ~((~bnr_oe_n & ~bnr_out_n) | hold_bnr);
  assign pri_wire_n = ~hold_pri;
endmodule // sys_agent_model

`default_nettype wire

// [power_on_config_and_init_test.sv]
// self-checking bench for the power-on configuration block
// assumes: design files and sys_agent_model compiled before this one
`default_nettype none
`define CHK(nm, got, ex) begin n_tests++; if ((got) !== (ex)) begin \
  miscompares++; $display("BAD %s exp %0h got %0h", nm, ex, got); end end

module power_on_config_and_init_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned PLL       = 2;
  localparam logic [31:0] RW_BITS   = 32'h0400_00DE;
  localparam logic [63:0] RATIO_TAB = 64'h3DEF_89AB_4567_012C;

  logic        clk, nrst, flush_n, init_n, addr_pin_5_n, addr_pin_6_n;
  logic        addr_pin_7_n, addr_pin_8_n, addr_pin_10_n, addr_pin_11_n;
  logic        addr_pin_12_n, address_bit20_mask_n, ignore_numeric_error_n;
  logic        address_strobe_n, block_next_request_in_n, bist_done;
  logic        priority_agent_request_n, msr_wr, msr_rd, msr_rvalid;
  logic        data_check_en, resp_check_en, address_error_drv_en;
  logic        bus_error_bus_drv_en, bus_error_int_drv_en, standby_en;
  logic        bus_initialize_drv_en, block_next_request_out_n;
  logic        block_next_request_oe_n, bist_start, fetch_req;
  logic        may_request, pins_normal, straps_latched, hold_pri, hold_bnr;
  logic [1:0]  local_interrupt_pins, bus_arb_id, agent_sel;
  logic [3:0]  bus_request_line_n, intc_arb_id;
  logic [31:0] msr_wdata, msr_rdata, rd;
  logic [39:0] fetch_addr;
  int          miscompares, n_tests, cyc;
  wire  [6:0]  en = {standby_en, bus_initialize_drv_en, bus_error_int_drv_en,
    bus_error_bus_drv_en, address_error_drv_en, resp_check_en, data_check_en};

  power_on_config_and_init #(.PLL_LOCK_CYCLES(PLL))
    power_on_config_and_init_inst (.clk, .nrst, .flush_n, .init_n,
    .addr_pin_5_n, .addr_pin_6_n, .addr_pin_7_n, .addr_pin_8_n,
    .addr_pin_10_n, .addr_pin_11_n, .addr_pin_12_n, .bus_request_line_n,
    .local_interrupt_pins, .address_bit20_mask_n, .ignore_numeric_error_n,
    .address_strobe_n, .block_next_request_in_n, .priority_agent_request_n,
    .bist_done, .msr_wr, .msr_rd, .msr_wdata, .msr_rdata, .msr_rvalid,
    .data_check_en, .resp_check_en, .address_error_drv_en,
    .bus_error_bus_drv_en, .bus_error_int_drv_en, .bus_initialize_drv_en,
    .standby_en, .block_next_request_out_n, .block_next_request_oe_n,
    .bist_start, .fetch_req, .fetch_addr, .bus_arb_id, .intc_arb_id,
    .may_request, .pins_normal, .straps_latched);

  sys_agent_model sys_agent_model_inst (.nrst, .agent_sel, .hold_pri,
    .hold_bnr, .bnr_out_n(block_next_request_out_n),
    .bnr_oe_n(block_next_request_oe_n), .bus_request_line_n,
    .bnr_wire_n(block_next_request_in_n),
    .pri_wire_n(priority_agent_request_n));

  // ==================================================================
  // clock and hang guard
  always #50 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      miscompares++;
      stop_test();
    end
  end

  // ==================================================================
  // helpers
  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // p: 0 flush 1 init 2..8 addr 5,6,7,8,10,11,12 9..10 lint 11 a20 12 ign
  task automatic set_pins(input logic [12:0] p);
    {ignore_numeric_error_n, address_bit20_mask_n, local_interrupt_pins,
     addr_pin_12_n, addr_pin_11_n, addr_pin_10_n, addr_pin_8_n,
     addr_pin_7_n, addr_pin_6_n, addr_pin_5_n, init_n, flush_n} <= p;
  endtask

  // flag and cluster straps are active low, so a low pin reads as a set bit; arbitration and ratio fields are not
  function automatic logic [31:0] exp_ro(logic [12:0] p, logic [1:0] ag);
    logic [31:0] e;
    e = 32'h0000_0000;
    {e[12], e[10], e[13], e[14], e[15], e[9], e[8]} = ~p[6:0];
    e[17:16] = ~p[8:7];
    e[21:20] = p[2] ? ag : {ag[1], 1'b0};
    e[25:22] = RATIO_TAB[{p[10:9], p[12], p[11]} * 4 +: 4];
    return e;
  endfunction

  task automatic msr_read(output logic [31:0] d);
    @(posedge clk);
    msr_rd <= 1'b1;
    @(posedge clk);
    msr_rd <= 1'b0;
    @(negedge clk);
    `CHK("rvalid", msr_rvalid, 1'b1);
    d = msr_rdata;
  endtask

  task automatic msr_write(input logic [31:0] d);
    @(posedge clk);
    msr_wr <= 1'b1;
    msr_wdata <= d;
    @(posedge clk);
    msr_wr <= 1'b0;
  endtask

  task automatic wait_for(ref logic s, input int lim);
    for (int k = 0; k < lim && s !== 1'b1; k++)
      @(negedge clk);
  endtask

  // ==================================================================
  // one reset and bring-up per case; i picks ratio code and agent id
  task automatic run_case(input int i);
    logic [12:0] p;
    logic [31:0] ro, d;
    logic [39:0] vec;
    int          st;
    p = 13'($urandom);
    if (i == 15) p = '1;
    if (i == 0) p = '0;
    {p[10], p[9], p[12], p[11]} = 4'(i);
    ro = exp_ro(p, 2'(i));
    vec = p[3] ? 40'h00_FFFF_FFF0 : 40'h00_000F_FFF0;
    @(posedge clk);
    nrst <= 1'b0;
    agent_sel <= 2'(i);
    {hold_pri, hold_bnr} <= 2'($urandom);
    set_pins(p);
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    st = 0;
    @(negedge clk);
    for (int k = 0; k < 40 && bist_start !== 1'b1 && fetch_req !== 1'b1;
         k++) begin
      if ({block_next_request_oe_n, block_next_request_out_n} === 2'b00)
        st++;
      @(negedge clk);
    end
    `CHK("stall_len", st, PLL + 1);
    `CHK("bnr_oe_n", block_next_request_oe_n, 1'b1);
    `CHK("bist_start", bist_start, ~p[1]);
    `CHK("bus_arb", bus_arb_id, ro[21:20]);
    `CHK("intc_arb", intc_arb_id, {ro[17:16], 2'(i)});
    `CHK("latched", straps_latched, 1'b1);
    if (!p[1]) begin
      repeat (3) @(negedge clk);
      `CHK("bist_hold", {bist_start, fetch_req}, 2'b10);
      @(posedge clk);
      bist_done <= 1'b1;
      @(posedge clk);
      bist_done <= 1'b0;
    end
    wait_for(fetch_req, 6);
    `CHK("fetch_req", fetch_req, 1'b1);
    @(negedge clk);
    `CHK("fetch_addr", fetch_addr, vec);
    `CHK("fetch_pulse", fetch_req, 1'b0);
    if (hold_pri | hold_bnr)
      `CHK("may_req_held", may_request, 1'b0);
    @(posedge clk);
    {hold_pri, hold_bnr} <= 2'b00;
    set_pins(~p);
    wait_for(may_request, 8);
    `CHK("may_request", may_request, 1'b1);
    `CHK("pins_held", pins_normal, 1'b0);
    `CHK("en_reset", en, 7'h40);
    msr_read(rd);
    `CHK("rd_reset", rd, ro | 32'h0400_0000);
    d = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0000_0000 : $urandom;
    msr_write(d);
    @(negedge clk);
    `CHK("en_write", en, {d[26], d[7:6], d[4:1]});
    msr_read(rd);
    `CHK("rd_write", rd, ro | (d & RW_BITS));
    @(posedge clk);
    address_strobe_n <= 1'b0;
    @(posedge clk);
    address_strobe_n <= 1'b1;
    @(negedge clk);
    `CHK("pins_normal", pins_normal, 1'b1);
  endtask

  // ==================================================================
  // main sequence: corner straps first (all high), then every ratio code
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    address_strobe_n = 1'b1;
    bist_done = 1'b0;
    msr_wr = 1'b0;
    msr_rd = 1'b0;
    msr_wdata = 32'h0000_0000;
    agent_sel = 2'b00;
    hold_pri = 1'b0;
    hold_bnr = 1'b0;
    {ignore_numeric_error_n, address_bit20_mask_n, local_interrupt_pins,
     addr_pin_12_n, addr_pin_11_n, addr_pin_10_n, addr_pin_8_n,
     addr_pin_7_n, addr_pin_6_n, addr_pin_5_n, init_n, flush_n} = '1;
    void'($urandom(47033));
    for (int i = 15; i >= 0; i--)
      run_case(i);
    stop_test();
  end
endmodule // power_on_config_and_init_test

`default_nettype wire
